// ===== hdl/vou_top.sv
// Video output unit, data streaming and message modes, with APB registers.
// Assumes a same-clock memory read port and an external byte clock pin.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module vou_top
   import vou_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] apb_paddr_in,
   input wire logic apb_psel_in,
   input wire logic apb_penable_in,
   input wire logic apb_pwrite_in,
   input wire logic [31:0] apb_pwdata_in,
   output logic [31:0] apb_prdata_out,
   output logic apb_pready_out,
   output logic apb_pslverr_out,
   output logic mem_req_out,
   output logic [31:0] mem_addr_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in,
   input wire logic out_byte_clock_in,
   output logic [7:0] out_byte_bus_out,
   output logic timing_line_one_out,
   output logic timing_line_two_out,
   input wire logic global_power_down_in,
   output logic irq_out,
   output logic wake_out,
   output logic asleep_out
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] ctl;
   logic [NFLAG-1:0] flags;
   logic [NFLAG-1:0] flag_set;
   logic [31:0] ptr1;
   logic [31:0] ptr2;
   logic [15:0] blen;
   logic [15:0] thr;
   logic [31:0] frame_timing_reg;
   logic [31:0] line_timing_reg;
   logic rdy1;
   logic rdy2;
   logic msg_done;
   logic apb_acc;
   logic apb_wr;
   logic [NFLAG-1:0] w_ack;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic unit_run_bit;
   logic enhanced_run_bit;
   logic [1:0] mode;
   logic take1;
   logic take2;
   logic st_busy;
   assign unit_run_bit = ctl[CTL_RUN];
   assign enhanced_run_bit = ctl[CTL_ERUN];
   assign mode = ctl[CTL_MODE +: 2];
   assign apb_acc = apb_psel_in & apb_penable_in;
   assign apb_wr = apb_acc & apb_pready_out & apb_pwrite_in;
   assign w_ack = (apb_wr && apb_paddr_in == ADR_CTL) ?
      apb_pwdata_in[CTL_ACK +: NFLAG] : '0;
   always_comb begin
      rd_ok = 1'b1;
      case (apb_paddr_in)
         ADR_CTL: rd_mux = {ctl[31:CTL_ACK+NFLAG], {NFLAG{1'b0}}, ctl[CTL_ACK-1:0]};
         ADR_STAT: rd_mux = {25'h0, asleep_out, st_busy, flags};
         ADR_PTR1: rd_mux = ptr1;
         ADR_PTR2: rd_mux = ptr2;
         ADR_BLEN: rd_mux = {16'h0, blen};
         ADR_THR: rd_mux = {16'h0, thr};
         ADR_FRAME: rd_mux = frame_timing_reg;
         ADR_LINE: rd_mux = line_timing_reg;
         default: begin
            rd_mux = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end
   // One wait state: pready rises in the second access cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         apb_pready_out <= 1'b0;
         apb_prdata_out <= RST_WORD;
         apb_pslverr_out <= 1'b0;
      end else begin
         apb_pready_out <= apb_acc & ~apb_pready_out;
         apb_pslverr_out <= apb_acc & ~apb_pready_out & ~rd_ok;
         if (apb_acc && !apb_pready_out) begin
            apb_prdata_out <= apb_pwrite_in ? RST_WORD : rd_mux;
         end
      end
   end
   // Acknowledge bits are pulses and never stored
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ctl <= RST_WORD;
         ptr1 <= RST_WORD;
         ptr2 <= RST_WORD;
         blen <= RST_HALF;
         thr <= RST_HALF;
         frame_timing_reg <= RST_WORD;
         line_timing_reg <= RST_WORD;
      end else begin
         if (msg_done) begin
            ctl[CTL_RUN] <= 1'b0;
         end
         if (apb_wr) begin
            case (apb_paddr_in)
               ADR_CTL: ctl <= {apb_pwdata_in[31:CTL_ACK+NFLAG], {NFLAG{1'b0}},
                  apb_pwdata_in[CTL_ACK-1:0]};
               ADR_PTR1: ptr1 <= apb_pwdata_in;
               ADR_PTR2: ptr2 <= apb_pwdata_in;
               ADR_BLEN: blen <= apb_pwdata_in[15:0];
               ADR_THR: thr <= apb_pwdata_in[15:0];
               ADR_FRAME: frame_timing_reg <= apb_pwdata_in;
               ADR_LINE: line_timing_reg <= apb_pwdata_in;
               default: ;
            endcase
         end
      end
   end
   // ----------------------------------------
   // Status flags: hardware set beats acknowledge
   // ----------------------------------------
   for (genvar i = 0; i < NFLAG; i++) begin : g_flag
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            flags[i] <= 1'b0;
         end else if (flag_set[i]) begin
            flags[i] <= 1'b1;
         end else if (w_ack[i]) begin
            flags[i] <= 1'b0;
         end
      end
   end
   // Pointer writes alone do nothing; only the ready bits release them
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rdy1 <= 1'b0;
         rdy2 <= 1'b0;
      end else begin
         if (w_ack[ST_B1]) begin
            rdy1 <= 1'b1;
         end else if (take1) begin
            rdy1 <= 1'b0;
         end
         if (w_ack[ST_B2]) begin
            rdy2 <= 1'b1;
         end else if (take2) begin
            rdy2 <= 1'b0;
         end
      end
   end
   logic [NFLAG-1:0] live;
   assign live = flags & ctl[CTL_IEN +: NFLAG];
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
         wake_out <= 1'b0;
         asleep_out <= 1'b0;
      end else begin
         irq_out <= |live;
         wake_out <= global_power_down_in & ctl[CTL_SLEEP] & (|live);
         asleep_out <= global_power_down_in & ~ctl[CTL_SLEEP];
      end
   end
   // ----------------------------------------
   // Transfer engine
   // ----------------------------------------
   vou_state_t state;
   logic tick_raw;
   logic tick;
   logic cur_buf;
   logic [1:0] run_mode;
   logic run_lend;
   logic run_sm;
   logic run_ss;
   logic [31:0] act1;
   logic [31:0] act2;
   logic [31:0] fetch_addr;
   logic [14:0] fetch_left;
   logic [15:0] byte_cnt;
   logic [1:0] idx;
   logic [31:0] cur_word;
   logic [31:0] pf_word;
   logic pf_valid;
   logic run_go;
   logic need_word;
   logic [7:0] pick_byte;
   logic [15:0] cnt_nxt;
   vou_sync_edge u_clk (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .pin_in(out_byte_clock_in),
      .rise_out(tick_raw)
   );
   vou_byte_pick u_pick (
      .word_in((need_word && pf_valid) ? pf_word : cur_word),
      .idx_in(idx),
      .lend_in(run_lend),
      .byte_out(pick_byte)
   );
   // Powered down units ignore their byte clock, which freezes the byte output; S_NEXT still advances
   assign tick = tick_raw & ~asleep_out;
   assign run_go = unit_run_bit & enhanced_run_bit &
      (mode == VOU_MODE_STREAM || mode == VOU_MODE_MSG);
   assign st_busy = (state != S_IDLE);
   assign take1 = (state == S_NEXT) && !mem_req_out && !cur_buf && rdy1;
   assign take2 = (state == S_NEXT) && !mem_req_out && cur_buf && rdy2;
   assign need_word = (idx == 2'b00);
   assign cnt_nxt = byte_cnt + 16'h0001;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state <= S_IDLE;
         cur_buf <= 1'b0;
         run_mode <= VOU_MODE_VIDEO;
         run_lend <= 1'b0;
         run_sm <= 1'b0;
         run_ss <= 1'b0;
         act1 <= RST_WORD;
         act2 <= RST_WORD;
         fetch_addr <= RST_WORD;
         fetch_left <= 15'h0000;
         byte_cnt <= RST_HALF;
         idx <= 2'b00;
         cur_word <= RST_WORD;
         pf_word <= RST_WORD;
         pf_valid <= 1'b0;
         mem_req_out <= 1'b0;
         mem_addr_out <= RST_WORD;
         out_byte_bus_out <= 8'h00;
         timing_line_one_out <= 1'b0;
         timing_line_two_out <= 1'b0;
         flag_set <= '0;
         msg_done <= 1'b0;
      end else begin
         flag_set <= '0;
         msg_done <= 1'b0;
         // Fetching runs on even while data starves, as counters must advance
         if (mem_req_out && mem_ack_in) begin
            mem_req_out <= 1'b0;
            fetch_addr <= fetch_addr + 32'h0000_0004;
            fetch_left <= fetch_left - 15'h0001;
            if (state != S_IDLE && state != S_NEXT) begin
               pf_word <= mem_rdata_in;
               pf_valid <= 1'b1;
            end
         end else if (!mem_req_out && !pf_valid && fetch_left != 15'h0000 &&
            (state == S_PRE || state == S_SEND) && !asleep_out) begin
            mem_req_out <= 1'b1;
            mem_addr_out <= fetch_addr;
         end
         case (state)
            S_IDLE: begin
               idx <= 2'b00;
               if (run_go && !asleep_out) begin
                  cur_buf <= 1'b0;
                  state <= S_NEXT;
               end
            end
            S_NEXT: begin
               if (!mem_req_out) begin
                  // Mode and byte order sampled only here, once per buffer
                  run_mode <= mode;
                  run_lend <= ctl[CTL_LEND];
                  run_sm <= ctl[CTL_SMASTER];
                  run_ss <= ctl[CTL_SSTREAM];
                  if (take1) begin
                     act1 <= ptr1;
                     fetch_addr <= ptr1;
                  end else if (take2) begin
                     act2 <= ptr2;
                     fetch_addr <= ptr2;
                  end else begin
                     flag_set[ST_UNDERRUN_FLAG] <= 1'b1;
                     fetch_addr <= cur_buf ? act2 : act1;
                  end
                  fetch_left <= 15'((17'(blen) + 17'h00003) >> 2);
                  byte_cnt <= RST_HALF;
                  idx <= 2'b00;
                  pf_valid <= 1'b0;
                  // A running stream keeps its valid line and goes straight on
                  state <= timing_line_two_out ? S_SEND : S_PRE;
               end
            end
            S_PRE: begin
               if (!run_go) begin
                  state <= S_IDLE;
               end else if (tick) begin
                  timing_line_one_out <= run_sm;
                  state <= S_SEND;
               end
            end
            S_SEND: begin
               if (tick) begin
                  timing_line_one_out <= 1'b0;
                  if (!run_go && run_mode == VOU_MODE_STREAM) begin
                     timing_line_two_out <= 1'b0;
                     state <= S_IDLE;
                  end else begin
                     out_byte_bus_out <= pick_byte;
                     if (need_word) begin
                        if (pf_valid) begin
                           cur_word <= pf_word;
                           pf_valid <= 1'b0;
                        end else begin
                           flag_set[ST_HBE] <= 1'b1;
                        end
                     end
                     idx <= idx + 2'b01;
                     byte_cnt <= cnt_nxt;
                     if (run_mode == VOU_MODE_STREAM) begin
                        timing_line_two_out <= run_sm & run_ss;
                     end
                     if (cnt_nxt == thr) begin
                        flag_set[ST_YTR] <= 1'b1;
                     end
                     if (cnt_nxt == blen) begin
                        flag_set[cur_buf ? ST_B2 : ST_B1] <= 1'b1;
                        if (run_mode == VOU_MODE_MSG) begin
                           state <= S_POST;
                        end else begin
                           cur_buf <= ~cur_buf;
                           state <= S_NEXT;
                        end
                     end
                  end
               end
            end
            S_POST: begin
               if (tick) begin
                  if (!timing_line_two_out) begin
                     timing_line_two_out <= run_sm;
                     if (!run_sm) begin
                        msg_done <= 1'b1;
                        state <= S_IDLE;
                     end
                  end else begin
                     timing_line_two_out <= 1'b0;
                     msg_done <= 1'b1;
                     state <= S_IDLE;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   sequence seq_last_byte;
      state == S_SEND && tick && run_go && cnt_nxt == blen;
   endsequence
   sequence seq_starve;
      state == S_SEND && tick && run_go && need_word && !pf_valid;
   endsequence
   AST_IRQ_LEVEL: assert property ((|live) [*2] |-> irq_out)
      else $error("interrupt request dropped while enabled flag set");
   AST_STREAM_SWITCH: assert property (
      seq_last_byte ##0 run_mode == VOU_MODE_STREAM |=>
      state == S_NEXT && cur_buf != $past(cur_buf))
      else $error("stream did not switch to the other buffer");
   AST_DRAIN_FLAG: assert property (seq_last_byte |=> ##1
      flags[$past(cur_buf, 2) ? ST_B2 : ST_B1])
      else $error("drained flag not set after buffer end");
   AST_UNDERRUN_FLAG_REUSE: assert property (
      state == S_NEXT && !mem_req_out && !take1 && !take2 |=>
      $stable(act1) && $stable(act2) ##1 flags[ST_UNDERRUN_FLAG])
      else $error("underrun did not reuse old pointer");
   AST_HBE_FLAG: assert property (seq_starve |=> ##1 flags[ST_HBE])
      else $error("bandwidth error not flagged");
   AST_START_PULSE: assert property (
      state == S_PRE && tick && run_go && run_sm |=> timing_line_one_out)
      else $error("start pulse missing");
   AST_START_END: assert property (
      state == S_SEND && tick && timing_line_one_out |=> !timing_line_one_out)
      else $error("start pulse longer than one byte clock");
   AST_VALID_HOLD: assert property (
      run_mode == VOU_MODE_STREAM && timing_line_two_out && run_go &&
      state != S_IDLE |=> timing_line_two_out)
      else $error("stream valid line fell while running");
   AST_MSG_STOP: assert property (
      state == S_POST && tick && timing_line_two_out |=> state == S_IDLE
      ##1 (!unit_run_bit || $past(apb_wr)))
      else $error("message mode did not stop");
   AST_SLEEP_FREEZE: assert property (
      asleep_out && !mem_req_out && state != S_IDLE |=> !mem_req_out &&
      $stable(byte_cnt))
      else $error("engine moved while powered down");
   AST_MODE_LATCH: assert property (
      state != S_NEXT |=> $stable(run_mode) && $stable(run_lend))
      else $error("mode changed outside a buffer start");
endmodule

// ===== hdl/vou_pkg.sv
// Constants, register map and types of the video output unit data modes.
// Assumes a 32-bit APB register bus and one core clock.
package vou_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ADR_CTL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_PTR1 = 8'h08;
   localparam logic [7:0] ADR_PTR2 = 8'h0C;
   localparam logic [7:0] ADR_BLEN = 8'h10;
   localparam logic [7:0] ADR_THR = 8'h14;
   localparam logic [7:0] ADR_FRAME = 8'h18;
   localparam logic [7:0] ADR_LINE = 8'h1C;
   // ----------------------------------------
   // Control and status fields
   // ----------------------------------------
   localparam int CTL_RUN = 0;
   localparam int CTL_ERUN = 1;
   localparam int CTL_MODE = 2;
   localparam int CTL_SMASTER = 4;
   localparam int CTL_SSTREAM = 5;
   localparam int CTL_LEND = 6;
   localparam int CTL_OVL = 7;
   localparam int CTL_SLEEP = 8;
   localparam int CTL_IEN = 9;
   localparam int CTL_ACK = 14;
   localparam int NFLAG = 5;
   localparam int ST_B1 = 0;
   localparam int ST_B2 = 1;
   localparam int ST_HBE = 2;
   localparam int ST_UNDERRUN_FLAG = 3;
   localparam int ST_YTR = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_ASLEEP = 6;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_HALF = 16'h0000;
   typedef enum logic [1:0] {
      VOU_MODE_VIDEO = 2'b00,
      VOU_MODE_STREAM = 2'b01,
      VOU_MODE_MSG = 2'b10
   } vou_mode_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_NEXT = 3'b001,
      S_PRE = 3'b010,
      S_SEND = 3'b011,
      S_POST = 3'b100
   } vou_state_t;
endpackage

// ===== hdl/vou_sync_edge.sv
// Three-stage synchroniser with rising-edge detect for the byte clock pin.
// Assumes the pin is slow against the core clock (at most a quarter of it).
`timescale 1ns/1ps
module vou_sync_edge
   import vou_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic pin_in,
   output logic rise_out
);
   logic s1;
   logic s2;
   logic s3;
   logic level;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // A change counts only once the last two stages agree
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         level <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         rise_out <= 1'b0;
         if (s2 == s3 && s3 != level) begin
            level <= s3;
            rise_out <= s3;
         end
      end
   end
endmodule

// ===== hdl/vou_byte_pick.sv
// Byte lane selector for a packed memory word.
// Assumes index 0 is the lowest byte address of the word.
`timescale 1ns/1ps
module vou_byte_pick
   import vou_pkg::*;
(
   input wire logic [31:0] word_in,
   input wire logic [1:0] idx_in,
   input wire logic lend_in,
   output logic [7:0] byte_out
);
   logic [1:0] lane;
   always_comb begin
      lane = lend_in ? idx_in : ~idx_in;
      byte_out = word_in[{lane, 3'b000} +: 8];
   end
endmodule

// ===== tb/vou_far_model.sv
// Far side model: memory read port with adjustable latency and the byte clock source.
// Assumes the core clock for memory; the byte clock halts low while not in a frame.
`timescale 1ns/1ps
module vou_far_model(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic mem_req_in,
   input wire logic [31:0] mem_addr_in,
   input wire logic [5:0] lat_in,
   input wire logic clk_run_in,
   output logic mem_ack_out,
   output logic [31:0] mem_rdata_out,
   output logic byte_clk_out
);
   logic [5:0] wait_cnt;
   logic [7:0] a;
   assign a = mem_addr_in[7:0];
   // ----------------------------------------
   // Memory answer
   // ----------------------------------------
   // Grant after lat_in cycles of a held request
   // Image and overlay grant windows do not apply in data modes
   // Data outside the ack cycle inverts every cycle, so a stale word reappears on alternate cycles
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mem_ack_out <= 1'b0;
         wait_cnt <= 6'h00;
         mem_rdata_out <= 32'h0000_0000;
      end else if (mem_ack_out) begin
         mem_ack_out <= 1'b0;
         mem_rdata_out <= ~mem_rdata_out;
      end else if (mem_req_in && wait_cnt == lat_in) begin
         mem_ack_out <= 1'b1;
         mem_rdata_out <= {a, a + 8'h01, a + 8'h02, a + 8'h03};
         wait_cnt <= 6'h00;
      end else begin
         wait_cnt <= mem_req_in ? wait_cnt + 6'h01 : 6'h00;
         mem_rdata_out <= ~mem_rdata_out;
      end
   end
   // ----------------------------------------
   // Byte clock, 160 ns period
   // ----------------------------------------
   // Made here, not synthesised from the core clock
   initial begin
      byte_clk_out = 1'b0;
      forever begin
         #80;
         byte_clk_out = clk_run_in ? ~byte_clk_out : 1'b0;
      end
   end
endmodule

// ===== tb/test_vou_top.sv
// Self-checking bench of the video output unit data modes.
// Assumes the APB map and control bit positions of the unit package.
`timescale 1ns/1ps
module test_vou_top;
   import vou_pkg::*;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err, gpd, clk_run;
   logic mem_req, mem_ack, bclk, one, two, irq, wake, asleep, prev_one;
   logic [7:0] paddr, obyte;
   logic [5:0] lat;
   logic [31:0] pwdata, prdata, rd, mem_addr, mem_rdata;
   int fail_count, checks_done;
   vou_top vou_top_inst(.core_clk_in(core_clk), .rst_in(rst), .apb_paddr_in(paddr),
      .apb_psel_in(psel), .apb_penable_in(penable), .apb_pwrite_in(pwrite),
      .apb_pwdata_in(pwdata), .apb_prdata_out(prdata), .apb_pready_out(pready),
      .apb_pslverr_out(pslverr), .mem_req_out(mem_req), .mem_addr_out(mem_addr),
      .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata), .out_byte_clock_in(bclk),
      .out_byte_bus_out(obyte), .timing_line_one_out(one), .timing_line_two_out(two),
      .global_power_down_in(gpd), .irq_out(irq), .wake_out(wake), .asleep_out(asleep));
   vou_far_model vou_far_model_inst(.core_clk_in(core_clk), .rst_in(rst),
      .mem_req_in(mem_req), .mem_addr_in(mem_addr), .lat_in(lat), .clk_run_in(clk_run),
      .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata), .byte_clk_out(bclk));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task end_sim;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         end_sim();
      end
   endtask
   // Sample once per byte clock, just after its falling edge
   task tick;
      int n;
      n = 0;
      while (bclk !== 1'b1 && n < 40) begin @(posedge core_clk); n++; end
      while (bclk !== 1'b0 && n < 40) begin @(posedge core_clk); n++; end
      if (n >= 40) begin
         fail_count++;
         end_sim();
      end
   endtask
   task do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task regs_scn;
      do_reset();
      apb(0, ADR_CTL, 0);
      chk("ctl reset", rd, RST_WORD);
      apb(0, ADR_STAT, 0);
      chk("status reset", rd, RST_WORD);
      apb(1, ADR_THR, 32'hFFFF_FFFF);
      apb(0, ADR_THR, 0);
      chk("threshold width", rd, 32'h0000_FFFF);
      apb(1, ADR_FRAME, 32'h0108_020D);
      apb(0, ADR_FRAME, 0);
      chk("frame 525 timing", rd, 32'h0108_020D);
      apb(1, ADR_LINE, 32'h0000_0360);
      apb(0, ADR_LINE, 0);
      chk("line 625 timing", rd, 32'h0000_0360);
      apb(1, ADR_CTL, 32'h0007_C000);
      apb(0, ADR_CTL, 0);
      chk("ack bits read zero", rd, 32'h0000_0000);
      apb(0, 8'h20, 0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0000_0000);
   endtask
   task stream_scn;
      logic [7:0] got[$];
      int n;
      do_reset();
      lat <= 6'h00;
      apb(1, ADR_PTR1, 32'h0000_0140);
      apb(1, ADR_PTR2, 32'h0000_0280);
      apb(1, ADR_BLEN, 32'h0000_0008);
      // Unused control bits stay zero, sync master set, both buffers ready
      apb(1, ADR_CTL, 32'h0000_C237);
      clk_run <= 1'b1;
      prev_one = 1'b0;
      n = 0;
      while (got.size() < 16 && n < 60) begin
         tick();
         n++;
         if (two === 1'b1) got.push_back(obyte);
         else if (got.size() > 0) chk("valid gap", {31'h0, two}, 32'h1);
         else prev_one = one;
      end
      chk("start pulse", {31'h0, prev_one}, 32'h1);
      for (int i = 0; i < 16; i++)
         chk("stream byte", {24'h0, got[i]}, {24'h0, (i < 8 ? 8'h40 : 8'h78) + 8'(i)});
      apb(0, ADR_STAT, 0);
      chk("drained and underrun", rd & 32'h0000_000F, 32'h0000_000B);
      chk("irq level", {31'h0, irq}, 32'h1);
      gpd <= 1'b1;
      apb(1, ADR_CTL, 32'h0000_0337);
      repeat (3) @(posedge core_clk);
      chk("sleepless wake", {30'h0, wake, asleep}, 32'h2);
      apb(1, ADR_CTL, 32'h0000_4237);
      apb(1, ADR_CTL, 32'h0000_0000);
      repeat (3) @(posedge core_clk);
      chk("irq cleared, asleep", {30'h0, irq, asleep}, 32'h1);
      gpd <= 1'b0;
      repeat (3) @(posedge core_clk);
      tick();
      tick();
      chk("valid drops", {31'h0, two}, 32'h0);
      clk_run <= 1'b0;
   endtask
   task msg_scn;
      int n;
      do_reset();
      lat <= 6'h03;
      apb(1, ADR_PTR1, 32'h0000_01C0);
      apb(1, ADR_BLEN, 32'h0000_0004);
      apb(1, ADR_CTL, 32'h0000_C21B);
      clk_run <= 1'b1;
      n = 0;
      while (one !== 1'b1 && n < 20) begin tick(); n++; end
      chk("message start", {31'h0, one}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         tick();
         chk("message byte", {24'h0, obyte}, {24'h0, 8'hC0 + 8'(i)});
      end
      tick();
      chk("end pulse", {30'h0, one, two}, 32'h1);
      tick();
      chk("end released", {31'h0, two}, 32'h0);
      clk_run <= 1'b0;
      apb(0, ADR_CTL, 0);
      chk("run cleared", rd & 32'h0000_0001, 32'h0);
      apb(0, ADR_STAT, 0);
      chk("buffer one drained", rd & 32'h0000_0001, 32'h1);
      chk("message irq", {31'h0, irq}, 32'h1);
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      gpd = 1'b0;
      clk_run = 1'b0;
      lat = 6'h00;
      fail_count = 0;
      checks_done = 0;
      @(posedge core_clk);
      regs_scn();
      stream_scn();
      msg_scn();
      end_sim();
   end
   initial begin
      repeat (90000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end
endmodule
